// ===== verilog/fbp_port.sv
`timescale 1ns/10ps
module fbp_port
  import fbp_pkg::*;
#(
  parameter int DEPTH = fbp_pkg::FBP_DEPTH
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire fbp_pkg::fbp_mode_t         mode,
  input  wire logic                       txsel_n,
  input  wire logic                       rxsel_n,
  input  wire logic                       port_pick,
  input  wire logic                       tx_port_pick,
  input  wire logic [fbp_pkg::FBP_DW-1:0] fdat_in,
  output logic [fbp_pkg::FBP_DW-1:0]      fdat_out,
  output logic [fbp_pkg::FBP_DW-1:0]      fdat_oe,
  input  wire logic [fbp_pkg::FBP_BEW-1:0] fbe_n_in,
  output logic [fbp_pkg::FBP_BEW-1:0]     fbe_n_out,
  output logic [fbp_pkg::FBP_BEW-1:0]     fbe_n_oe,
  input  wire logic                       sop_in,
  input  wire logic                       eop_in,
  output logic                            sop_out,
  output logic                            eop_out,
  output logic                            flag_oe,
  output logic                            rx_fail,
  output logic                            rx_fail_oe,
  output logic                            rx_empty0,
  output logic                            rx_empty1,
  output logic                            tx_stall,
  input  wire fbp_pkg::fbp_word_t         mac_rx_word0,
  input  wire logic                       mac_rx_valid0,
  output logic                            mac_rx_ready0,
  input  wire fbp_pkg::fbp_word_t         mac_rx_word1,
  input  wire logic                       mac_rx_valid1,
  output logic                            mac_rx_ready1,
  output fbp_pkg::fbp_word_t              mac_tx_word0,
  output logic                            mac_tx_valid0,
  input  wire logic                       mac_tx_ready0,
  output fbp_pkg::fbp_word_t              mac_tx_word1,
  output logic                            mac_tx_valid1,
  input  wire logic                       mac_tx_ready1
);
  import fbp_pkg::*;

  // ==========================================
  // port selection
  logic      rx_port;
  logic      tx_port;
  logic      split;
  logic      narrow;
  fbp_word_t tx_word;
  fbp_word_t rxq_word [2];
  logic [1:0] rxq_valid;
  logic [1:0] rxq_ready;
  logic [1:0] txq_valid;
  logic [1:0] txq_ready;
  fbp_word_t txq_word [2];
  fbp_word_t rx_pick;
  logic       rd_go;
  logic       wr_go;

  assign split   = (mode == FBP_MODE_SPLIT);
  assign narrow  = (mode == FBP_MODE_NARROW);
  assign rx_port = port_pick;
  assign tx_port = split ? tx_port_pick : port_pick;

  // ==========================================
  // transmit word assembly from the bus
  always_comb begin
    tx_word = '0;
    if (split) begin
      tx_word.data[FBP_HW-1:0]   = fdat_in[FBP_DW-1:FBP_HW];
      tx_word.be_n               = {{FBP_HBEW{1'b1}}, fbe_n_in[FBP_BEW-1:FBP_HBEW]};
    end else if (narrow) begin
      tx_word.data[FBP_HW-1:0]   = fdat_in[FBP_HW-1:0];
      tx_word.be_n               = {{FBP_HBEW{1'b1}}, fbe_n_in[FBP_HBEW-1:0]};
    end else begin
      tx_word.data               = fdat_in;
      tx_word.be_n               = fbe_n_in;
    end
    tx_word.sop = sop_in;
    tx_word.eop = eop_in;
  end

  // in full and narrow the bus is turned round, so no write while reading
  assign wr_go = !txsel_n && (split || rxsel_n);
  assign rd_go = !rxsel_n;

  // ==========================================
  // per-port fifos; reset flushes them
  for (genvar p = 0; p < 2; p++) begin : g_q
    assign txq_valid[p] = wr_go && (tx_port == 1'(p));
    fbp_fifo #(.W(FBP_WW), .D(DEPTH)) u_tx (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_data   (tx_word),
      .in_valid  (txq_valid[p]),
      .in_ready  (txq_ready[p]),
      .out_data  (txq_word[p]),
      .out_valid (),
      .out_ready (p == 0 ? mac_tx_ready0 : mac_tx_ready1)
    );
    fbp_fifo #(.W(FBP_WW), .D(DEPTH)) u_rx (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_data   (p == 0 ? mac_rx_word0 : mac_rx_word1),
      .in_valid  (p == 0 ? mac_rx_valid0 : mac_rx_valid1),
      .in_ready  (rxq_ready[p]),
      .out_data  (rxq_word[p]),
      .out_valid (rxq_valid[p]),
      .out_ready (rd_go && (rx_port == 1'(p)))
    );
  end

  assign mac_rx_ready0 = rxq_ready[0];
  assign mac_rx_ready1 = rxq_ready[1];
  assign mac_tx_word0  = txq_word[0];
  assign mac_tx_word1  = txq_word[1];

  // tx valid tracked from the fifo fill, registered for clean outputs
  // counter width follows the fifo depth so a deeper fifo cannot wrap it
  localparam int CW = $clog2(DEPTH) + 1;
  logic [CW-1:0] txc0_reg;
  logic [CW-1:0] txc1_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      txc0_reg <= '0;
      txc1_reg <= '0;
    end else begin
      txc0_reg <= txc0_reg + CW'(txq_valid[0] && txq_ready[0])
                  - CW'(mac_tx_valid0 && mac_tx_ready0);
      txc1_reg <= txc1_reg + CW'(txq_valid[1] && txq_ready[1])
                  - CW'(mac_tx_valid1 && mac_tx_ready1);
    end
  end
  assign mac_tx_valid0 = (txc0_reg != '0);
  assign mac_tx_valid1 = (txc1_reg != '0);

  // ==========================================
  // read path: register word and enables onto the bus
  assign rx_pick = rxq_word[rx_port];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fdat_out   <= '0;
      fbe_n_out  <= '1;
      sop_out    <= 1'b0;
      eop_out    <= 1'b0;
      rx_fail    <= 1'b0;
    end else if (rd_go && rxq_valid[rx_port]) begin
      fdat_out   <= rx_pick.data;
      fbe_n_out  <= rx_pick.be_n;
      sop_out    <= rx_pick.sop;
      eop_out    <= rx_pick.eop;
      rx_fail    <= rx_pick.fail;
    end else begin
      fbe_n_out  <= '1;   // empty fifo shows no valid byte
      sop_out    <= 1'b0;
      eop_out    <= 1'b0;
      rx_fail    <= 1'b0;
    end
  end

  // enables follow rx select one cycle later, in step with the data
  always_ff @(posedge clk_sys) begin
    if (!rstn || rxsel_n) begin
      fdat_oe    <= '0;
      fbe_n_oe   <= '0;
      flag_oe    <= 1'b0;
      rx_fail_oe <= 1'b0;
    end else if (mode == FBP_MODE_FULL) begin
      fdat_oe    <= '1;
      fbe_n_oe   <= '1;
      flag_oe    <= 1'b1;
      rx_fail_oe <= 1'b1;
    end else begin
      fdat_oe    <= {{FBP_HW{1'b0}}, {FBP_HW{1'b1}}};
      fbe_n_oe   <= {{FBP_HBEW{1'b0}}, {FBP_HBEW{1'b1}}};
      flag_oe    <= 1'b1;
      rx_fail_oe <= 1'b1;
    end
  end

  // status
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_empty0 <= 1'b1;
      rx_empty1 <= 1'b1;
      tx_stall  <= 1'b0;
    end else begin
      rx_empty0 <= !rxq_valid[0];
      rx_empty1 <= !rxq_valid[1];
      tx_stall  <= wr_go && !txq_ready[tx_port];
    end
  end
endmodule : fbp_port

// ===== verilog/fbp_pkg.sv
// Overview of operation
// - all fifo transfers run on clk_sys
// - transmit writes only while transmit select low
// - receive reads only while receive select low
// - full mode drives 64 data, 8 enables, flags
// - split mode drives low half and rx flags
// - narrow mode drives low half and flags
// - shared port pick: high port1, low port0
// - split: rx port pick chooses read port
// - split: tx port pick chooses write port
// - tx port pick ignored in full, narrow
// - reset clears registers and flushes fifos
// - full mode: whole bus bidirectional
// - split: low half out, high half in
package fbp_pkg;
  // ==========================================
  // bus organisation
  typedef enum logic [1:0] {
    FBP_MODE_FULL   = 2'h0,
    FBP_MODE_SPLIT  = 2'h1,
    FBP_MODE_NARROW = 2'h2
  } fbp_mode_t;

  localparam int FBP_DW      = 64;
  localparam int FBP_HW      = 32;
  localparam int FBP_BEW     = 8;
  localparam int FBP_HBEW    = 4;
  localparam int FBP_DEPTH   = 16;
  localparam int FBP_CLK_KHZ = 20000;
  localparam int FBP_RST_MS  = 1;
  // least reset hold in cycles, for reference by the bench
  localparam int FBP_RST_CYC = FBP_RST_MS * FBP_CLK_KHZ;

  // ==========================================
  // one fifo word: data, active-low enables, packet flags
  typedef struct packed {
    logic [FBP_DW-1:0]  data;
    logic [FBP_BEW-1:0] be_n;
    logic               sop;
    logic               eop;
    logic               fail;
  } fbp_word_t;

  localparam int FBP_WW = $bits(fbp_word_t);
endpackage : fbp_pkg

// ===== verilog/fbp_fifo.sv
`timescale 1ns/10ps
module fbp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          wr;
  logic          rd;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem[wp_reg] <= in_data;
    end
  end

  // reset flushes by clearing pointers and count
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (wr) begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (rd) begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule : fbp_fifo

// ===== dv/fbp_mac_model.sv
`timescale 1ns/10ps
// ======
// mac side: rx word source, tx sink
module fbp_mac_model
  import fbp_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rstn,
  input  wire logic           tx_hold,
  output fbp_pkg::fbp_word_t  mac_rx_word0,
  output logic                mac_rx_valid0,
  input  wire logic           mac_rx_ready0,
  output fbp_pkg::fbp_word_t  mac_rx_word1,
  output logic                mac_rx_valid1,
  input  wire logic           mac_rx_ready1,
  output logic                mac_tx_ready0,
  output logic                mac_tx_ready1
);
  logic [2:0] k0_reg;
  logic [2:0] k1_reg;
  // four-word packet per port; source stops after the last word, repeats only after reset
  function automatic fbp_word_t mk(input logic [7:0] p, input logic [2:0] k);
    fbp_word_t w;
    w      = '0;
    w.data = {2{16'h5a5a, p, 5'h0, k}};
    w.be_n = (k == 3'h3) ? 8'hf8 : 8'h00;
    w.sop  = (k == 3'h0);
    w.eop  = (k == 3'h3);
    return w;
  endfunction : mk
  assign mac_rx_word0  = mk(8'h00, k0_reg);
  assign mac_rx_word1  = mk(8'h01, k1_reg);
  assign mac_rx_valid0 = rstn && !k0_reg[2];
  assign mac_rx_valid1 = rstn && !k1_reg[2];
  // stall lets the bench see the tx fifo head
  assign mac_tx_ready0 = !tx_hold;
  assign mac_tx_ready1 = !tx_hold;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      k0_reg <= 3'h0;
      k1_reg <= 3'h0;
    end else begin
      k0_reg <= k0_reg + 3'(mac_rx_valid0 && mac_rx_ready0);
      k1_reg <= k1_reg + 3'(mac_rx_valid1 && mac_rx_ready1);
    end
  end
endmodule : fbp_mac_model

// ===== dv/fbp_port_sva.sv
`timescale 1ns/10ps
// ======
// port checker
module fbp_port_sva
  import fbp_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire fbp_pkg::fbp_mode_t mode,
  input wire logic               txsel_n,
  input wire logic               rxsel_n,
  input wire logic               port_pick,
  input wire logic               tx_port_pick,
  input wire logic [63:0]        fdat_oe,
  input wire logic [7:0]         fbe_n_oe,
  input wire logic               flag_oe,
  input wire logic               rx_fail_oe,
  input wire logic               rx_empty0,
  input wire logic               tx_stall,
  input wire logic               mac_tx_valid0,
  input wire logic               mac_tx_valid1
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_full_drive: assert property (
    !rxsel_n && mode == FBP_MODE_FULL |=> &fdat_oe && &fbe_n_oe && flag_oe && rx_fail_oe)
    else $error("full read not driven");
  a_half_drive: assert property (
    !rxsel_n && mode != FBP_MODE_FULL |=> fdat_oe == 64'h0000_0000_ffff_ffff
    && fbe_n_oe == 8'h0f && flag_oe && rx_fail_oe) else $error("half read drive wrong");
  a_bus_release: assert property (
    rxsel_n |=> fdat_oe == 64'h0 && fbe_n_oe == 8'h00 && !flag_oe && !rx_fail_oe)
    else $error("bus not released");
  a_reset_flush: assert property (
    disable iff (1'b0) !rstn |=> rx_empty0 && fdat_oe == 64'h0 && !mac_tx_valid0)
    else $error("reset did not flush");
  a_tx_cause: assert property (
    $rose(mac_tx_valid0) |-> $past(!txsel_n)) else $error("tx word without select");
  a_stall_cause: assert property (
    $rose(tx_stall) |-> $past(!txsel_n)) else $error("stall without write");
  a_rx_hold: assert property (
    !rx_empty0 && rxsel_n && $past(rxsel_n) && $past(rxsel_n, 2) |=> !rx_empty0)
    else $error("rx popped without select");
  a_split_port: assert property (
    !txsel_n && mode == FBP_MODE_SPLIT && tx_port_pick && !mac_tx_valid1 |=> mac_tx_valid1)
    else $error("split tx port wrong");
  a_full_port: assert property (
    !txsel_n && rxsel_n && mode == FBP_MODE_FULL && port_pick && !tx_port_pick
    && !mac_tx_valid1 |=> mac_tx_valid1) else $error("full tx port wrong");
  c_full_read: cover property (!rxsel_n && mode == FBP_MODE_FULL);
  c_split_both: cover property (!rxsel_n && !txsel_n && mode == FBP_MODE_SPLIT);
  c_stall: cover property ($rose(tx_stall));
endmodule : fbp_port_sva
bind fbp_port fbp_port_sva u_sva (.*);

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import fbp_pkg::*;
  logic        clk_sys;
  logic        rstn = 1'b0;
  fbp_mode_t   mode = FBP_MODE_FULL;
  logic        txsel_n = 1'b1, rxsel_n = 1'b1, port_pick = 1'b0, tx_port_pick = 1'b0;
  logic        sop_in = 1'b0, eop_in = 1'b0, tx_hold = 1'b1;
  logic [63:0] fdat_in = 64'h0, fdat_out, fdat_oe;
  logic [7:0]  fbe_n_in = 8'h00, fbe_n_out, fbe_n_oe;
  logic        flag_oe, rx_fail, rx_fail_oe, rx_empty0, rx_empty1, tx_stall, sop_out, eop_out;
  fbp_word_t   mac_rx_word0, mac_rx_word1, mac_tx_word0, mac_tx_word1;
  logic        mac_rx_valid0, mac_rx_valid1, mac_rx_ready0, mac_rx_ready1;
  logic        mac_tx_valid0, mac_tx_valid1, mac_tx_ready0, mac_tx_ready1;
  int          fails = 0, check_count = 0, cyc_cnt = 0;
  fbp_port uut (.*);
  fbp_mac_model mac (.*);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ======
  // helpers
  function automatic logic [63:0] exp_d(input logic [7:0] p, input logic [2:0] k);
    return {2{16'h5a5a, p, 5'h0, k}};
  endfunction : exp_d
  task automatic chk(input logic [63:0] a, input logic [63:0] e);
    check_count++;
    if (a !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk
  // one bus cycle; outputs settled on return
  task automatic bus(input logic rs, ts, pp, tp, input logic [63:0] d);
    @(posedge clk_sys);
    rxsel_n <= rs;
    txsel_n <= ts;
    port_pick <= pp;
    tx_port_pick <= tp;
    fdat_in <= d;
    @(posedge clk_sys);
    rxsel_n <= 1'b1;
    txsel_n <= 1'b1;
    #1;
  endtask : bus
  task automatic do_reset(input int hold);
    @(posedge clk_sys);
    rstn <= 1'b0;
    // hold length is the caller's; a system reset wants the long one
    repeat (hold) @(posedge clk_sys);
    #1;
    chk({rx_empty0, rx_empty1, mac_tx_valid0, mac_tx_valid1, fdat_oe != 0}, 5'h18);
    @(posedge clk_sys);
    rstn <= 1'b1;
  endtask : do_reset
  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // ======
  // scenarios
  task automatic t_full;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({rx_empty0, rx_empty1}, 2'h0);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 64'h0);
    chk(fdat_out, exp_d(8'h01, 3'h0));
    chk({fbe_n_out, sop_out, eop_out, rx_fail}, 11'h004);
    chk(fdat_oe, '1);
    bus(1'b0, 1'b1, 1'b0, 1'b1, 64'h0);
    chk(fdat_out, exp_d(8'h00, 3'h0));
    @(posedge clk_sys);
    #1;
    chk(fdat_oe, 64'h0);
    bus(1'b1, 1'b0, 1'b1, 1'b0, 64'h0123_4567_89ab_cdef);
    chk({mac_tx_valid0, mac_tx_valid1}, 2'h1);
    chk(mac_tx_word1.data, 64'h0123_4567_89ab_cdef);
  endtask : t_full
  task automatic t_fill;
    for (int i = 0; i < 16; i++) bus(1'b1, 1'b0, 1'b0, 1'b0, 64'(i));
    chk(tx_stall, 1'b0);
    bus(1'b1, 1'b0, 1'b0, 1'b0, 64'h99);
    chk(tx_stall, 1'b1);
    chk(mac_tx_word0.data, 64'h0);
    @(posedge clk_sys);
    tx_hold <= 1'b0;
    repeat (20) @(posedge clk_sys);
    tx_hold <= 1'b1;
    #1;
    chk({mac_tx_valid0, mac_tx_valid1}, 2'h0);
    bus(1'b1, 1'b0, 1'b0, 1'b0, 64'h5);
    // mid-run reset keeps the full system hold
    do_reset(FBP_RST_CYC);
  endtask : t_fill
  task automatic t_split;
    @(posedge clk_sys);
    mode <= FBP_MODE_SPLIT;
    repeat (8) @(posedge clk_sys);
    bus(1'b0, 1'b0, 1'b1, 1'b0, 64'hfeed_beef_0000_0000);
    chk(fdat_out[31:0], exp_d(8'h01, 3'h0) & 64'hffff_ffff);
    chk(fdat_oe, 64'h0000_0000_ffff_ffff);
    chk({mac_tx_valid0, mac_tx_valid1}, 2'h2);
    chk(mac_tx_word0.data[31:0], 32'hfeed_beef);
    bus(1'b1, 1'b0, 1'b0, 1'b1, 64'h1234_5678_0000_0000);
    chk({mac_tx_valid0, mac_tx_valid1}, 2'h3);
    chk(mac_tx_word1.data[31:0], 32'h1234_5678);
    // drain both heads so the narrow write starts from empty fifos
    @(posedge clk_sys);
    tx_hold <= 1'b0;
    @(posedge clk_sys);
    tx_hold <= 1'b1;
    #1;
    chk({mac_tx_valid0, mac_tx_valid1}, 2'h0);
  endtask : t_split
  task automatic t_narrow;
    @(posedge clk_sys);
    mode <= FBP_MODE_NARROW;
    bus(1'b0, 1'b1, 1'b0, 1'b1, 64'h0);
    chk(fdat_out[31:0], exp_d(8'h00, 3'h0) & 64'hffff_ffff);
    chk(fdat_oe, 64'h0000_0000_ffff_ffff);
    bus(1'b1, 1'b0, 1'b1, 1'b0, 64'h0000_0000_cafe_f00d);
    chk({mac_tx_valid0, mac_tx_valid1}, 2'h1);
    chk(mac_tx_word1.data[31:0], 32'hcafe_f00d);
  endtask : t_narrow
  // ======
  // main sequence and hang guard
  always @(posedge clk_sys) begin
    cyc_cnt++;
    // ceiling covers the long mid-run reset plus the scenarios
    if (cyc_cnt == FBP_RST_CYC + 2000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    do_reset(4);
    t_full();
    t_fill();
    t_split();
    t_narrow();
    give_verdict();
  end
endmodule : tb_top
